/* hw/cpu_timer_pkg.sv */
// constants shared by the periodic down timer and its bench
// assumes a 32-bit avalon-mm host that uses byte addresses
//
// What this block does
// - 32-bit down-counter loads from period register
// - counter decrements once per tick_prescale+1 enabled timer ticks
// - a decrement at zero reloads the period and gives a one-cycle pulse on timer_pulse_out
// - programmable prescaler sets input clocks per decrement
// - tick source chosen by software among five
// - readable overflow flag and software reload request
package cpu_timer_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL     = 5'h00; // timer_control_reg
    localparam logic [4:0] OFS_PERIOD   = 5'h04; // period value
    localparam logic [4:0] OFS_PRESCALE = 5'h08; // tick_prescale
    localparam logic [4:0] OFS_COUNT    = 5'h0c; // live count, read only
    localparam logic [4:0] OFS_STATUS   = 5'h10; // sticky events, w1c
    localparam logic [4:0] OFS_MASK     = 5'h14; // interrupt mask

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN_BIT    = 0;  // 1 lets the counter run
    localparam int CTRL_RELOAD_BIT = 1;  // reload_request, self clearing
    localparam int CTRL_SRC_LO     = 4;  // clock source select [6:4]
    localparam int CTRL_SRC_HI     = 6;
    localparam int STAT_OVF_BIT    = 0;  // overflow flag

    // ------------------------------------------------------------
    // tick source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_SYSTEM  = 3'h0; // system_clock
    localparam logic [2:0] SRC_OSC_ONE = 3'h1; // internal_osc_one
    localparam logic [2:0] SRC_OSC_TWO = 3'h2; // internal_osc_two
    localparam logic [2:0] SRC_CRYSTAL = 3'h3; // crystal_clock
    localparam logic [2:0] SRC_AUX_PLL = 3'h4; // auxiliary_pll_clock
    localparam int         NUM_EXT_SRC = 4;    // sources sampled on pins

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PERIOD   = 32'hffff_ffff;
    localparam logic [15:0] RST_PRESCALE = 16'h0000;
    localparam logic [31:0] RST_COUNT    = 32'hffff_ffff;
    localparam logic [2:0]  RST_SRC      = 3'h0;

endpackage

/* hw/cpu_periodic_down_timer.sv */
// periodic 32-bit down timer with prescaler and tick source select
// assumes one 100 mhz clock, async reset, avalon-mm master with
// waitrequest, and free-running oscillator pins from other domains
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
module cpu_periodic_down_timer
    import cpu_timer_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // avalon-mm slave
    input  wire logic [4:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // tick source pins, asynchronous to sys_clk_in
    input  wire logic        internal_osc_one_in,
    input  wire logic        internal_osc_two_in,
    input  wire logic        crystal_clock_in,
    input  wire logic        auxiliary_pll_clock_in,
    // timer outputs
    output logic             timer_pulse_out,
    output logic             irq_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   wait_r;    // waitrequest level
        logic [31:0]            rdata_r;   // read data to master
        logic                   run_r;     // counter enabled
        logic [2:0]             src_r;     // tick source select
        logic [31:0]            period_r;  // period value
        logic [15:0]            pscset_r;  // tick_prescale setting
        logic [31:0]            count_r;   // main down-counter
        logic [15:0]            psc_r;     // prescale down-counter
        logic                   ovf_r;     // sticky overflow flag
        logic                   mask_r;    // overflow interrupt mask
        logic                   irq_r;     // registered interrupt
        logic                   pulse_r;   // one-cycle zero pulse
        logic [NUM_EXT_SRC-1:0] sync1_r;   // first synchroniser stage
        logic [NUM_EXT_SRC-1:0] sync2_r;   // second stage
        logic [NUM_EXT_SRC-1:0] sync3_r;   // edge history
    } state_t;

    state_t st_r;   // registered state
    state_t st_nxt; // next state

    logic             req;      // a bus request is present
    logic             wr_go;    // write takes effect this edge
    logic             tick_go;  // selected source edge seen
    logic             dec_go;   // main counter steps this edge
    logic             rel_go;   // software reload accepted
    logic [NUM_EXT_SRC-1:0] src_pins; // raw oscillator pins

    assign src_pins = {auxiliary_pll_clock_in, crystal_clock_in,
                       internal_osc_two_in, internal_osc_one_in};

    // merge write data into an old word under the byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wdat;   // merged write word
        wdat   = 32'h0000_0000;
        st_nxt = st_r;
        req    = read_in | write_in;
        // the write lands on the edge where waitrequest is seen low
        wr_go  = write_in & ~st_r.wait_r;
        rel_go = 1'b0;

        // synchronisers: stage one feeds stage two only
        st_nxt.sync1_r = src_pins;
        st_nxt.sync2_r = st_r.sync1_r;
        st_nxt.sync3_r = st_r.sync2_r;

        // tick source; undefined codes stop the timer
        case (st_r.src_r)
            SRC_SYSTEM:  tick_go = 1'b1;
            SRC_OSC_ONE: tick_go = st_r.sync2_r[0] & ~st_r.sync3_r[0];
            SRC_OSC_TWO: tick_go = st_r.sync2_r[1] & ~st_r.sync3_r[1];
            SRC_CRYSTAL: tick_go = st_r.sync2_r[2] & ~st_r.sync3_r[2];
            SRC_AUX_PLL: tick_go = st_r.sync2_r[3] & ~st_r.sync3_r[3];
            default:     tick_go = 1'b0;
        endcase
        tick_go = tick_go & st_r.run_r;

        // prescaler: pscset+1 ticks make one decrement
        dec_go = tick_go & (st_r.psc_r == 16'h0000);
        if (tick_go) begin
            if (st_r.psc_r == 16'h0000) begin
                st_nxt.psc_r = st_r.pscset_r;
            end else begin
                st_nxt.psc_r = st_r.psc_r - 16'h0001;
            end
        end

        // main counter: step, or wrap on zero with a pulse
        st_nxt.pulse_r = 1'b0;
        if (dec_go) begin
            if (st_r.count_r == 32'h0000_0000) begin
                st_nxt.count_r = st_r.period_r;
                st_nxt.pulse_r = 1'b1;
            end else begin
                st_nxt.count_r = st_r.count_r - 32'h0000_0001;
            end
        end

        // waitrequest drops for exactly one cycle per request
        st_nxt.wait_r = ~(req & st_r.wait_r);

        // read data is captured one edge ahead so it stands stable
        if (read_in & st_r.wait_r) begin
            case (address_in)
                OFS_CTRL: begin
                    st_nxt.rdata_r = 32'h0000_0000;
                    st_nxt.rdata_r[CTRL_RUN_BIT] = st_r.run_r;
                    st_nxt.rdata_r[CTRL_SRC_HI:CTRL_SRC_LO] = st_r.src_r;
                end
                OFS_PERIOD:   st_nxt.rdata_r = st_r.period_r;
                OFS_PRESCALE: st_nxt.rdata_r = {16'h0000, st_r.pscset_r};
                OFS_COUNT:    st_nxt.rdata_r = st_r.count_r;
                OFS_STATUS:   st_nxt.rdata_r = {31'h0, st_r.ovf_r};
                OFS_MASK:     st_nxt.rdata_r = {31'h0, st_r.mask_r};
                default:      st_nxt.rdata_r = 32'h0000_0000; // unmapped
            endcase
        end

        // register writes; unmapped writes are dropped
        if (wr_go) begin
            case (address_in)
                OFS_CTRL: begin
                    wdat = merge_be({25'h0, st_r.src_r, 3'h0, st_r.run_r},
                                    writedata_in, byteenable_in);
                    st_nxt.run_r = wdat[CTRL_RUN_BIT];
                    st_nxt.src_r = wdat[CTRL_SRC_HI:CTRL_SRC_LO];
                    rel_go       = wdat[CTRL_RELOAD_BIT];
                end
                OFS_PERIOD: begin
                    st_nxt.period_r = merge_be(st_r.period_r, writedata_in,
                                               byteenable_in);
                end
                OFS_PRESCALE: begin
                    wdat = merge_be({16'h0000, st_r.pscset_r}, writedata_in,
                                    byteenable_in);
                    st_nxt.pscset_r = wdat[15:0];
                end
                OFS_MASK: begin
                    if (byteenable_in[0]) begin
                        st_nxt.mask_r = writedata_in[STAT_OVF_BIT];
                    end
                end
                default: begin
                    wdat = 32'h0000_0000; // status handled below
                end
            endcase
        end

        // reload request beats a same-edge step or wrap of count and prescaler; a same-edge wrap still pulses and sets the flag
        if (rel_go) begin
            st_nxt.count_r = st_r.period_r;
            st_nxt.psc_r   = st_r.pscset_r;
        end

        // sticky flag: write-one clears, a new event wins
        if (wr_go && address_in == OFS_STATUS && byteenable_in[0] &&
            writedata_in[STAT_OVF_BIT]) begin
            st_nxt.ovf_r = 1'b0;
        end
        if (st_nxt.pulse_r) begin
            st_nxt.ovf_r = 1'b1;
        end

        // level interrupt while an unmasked flag stands
        st_nxt.irq_r = st_nxt.ovf_r & st_nxt.mask_r;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r          <= '0;
            st_r.wait_r   <= 1'b1;
            st_r.src_r    <= RST_SRC;
            st_r.period_r <= RST_PERIOD;
            st_r.pscset_r <= RST_PRESCALE;
            st_r.count_r  <= RST_COUNT;
            st_r.psc_r    <= RST_PRESCALE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata_out    = st_r.rdata_r;
    assign waitrequest_out = st_r.wait_r;
    assign timer_pulse_out = st_r.pulse_r;
    assign irq_out         = st_r.irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_count_hold: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) !dec_go && !rel_go |=> $stable(st_r.count_r))
        else $error("count moved without a step or reload");

    chk_count_step: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        dec_go && !rel_go && st_r.count_r != 32'h0000_0000
        |=> st_r.count_r == $past(st_r.count_r) - 32'h0000_0001)
        else $error("count did not step down by one");

    chk_pulse_single: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        timer_pulse_out && st_r.period_r != 32'h0000_0000
        |=> !timer_pulse_out)
        else $error("zero pulse lasted more than one cycle");

    chk_psc_step: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        tick_go && !rel_go && st_r.psc_r != 16'h0000
        |=> st_r.psc_r == $past(st_r.psc_r) - 16'h0001 && !timer_pulse_out)
        else $error("prescaler did not step or pulse came early");

    chk_src_stop: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (st_r.src_r > SRC_AUX_PLL || !st_r.run_r) |-> !tick_go)
        else $error("tick seen from a stopped or undefined source");

    chk_reload_req: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        rel_go |=> st_r.count_r == $past(st_r.period_r)
                   && st_r.psc_r == $past(st_r.pscset_r))
        else $error("reload request did not load the period");

    chk_wrap_ovf: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        dec_go && !rel_go && st_r.count_r == 32'h0000_0000
        |=> st_r.count_r == $past(st_r.period_r) && timer_pulse_out
            && st_r.ovf_r && irq_out == st_r.mask_r)
        else $error("zero did not reload, pulse and set the flag");

    chk_ovf_sticky: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        st_r.ovf_r && !(wr_go && address_in == OFS_STATUS)
        |=> st_r.ovf_r)
        else $error("overflow flag fell without a clear");

    chk_bus_wait: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        req && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
        else $error("waitrequest did not drop for one cycle");

endmodule

/* sim/test_cpu_periodic_down_timer.sv */
// self-checking bench for the periodic down timer
// assumes the design's one-wait-cycle avalon slave and a 100 mhz clock
`timescale 1ns/100ps
module test_cpu_periodic_down_timer;
    import cpu_timer_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        sys_clk_in    = 1'b0;
    logic        rst_in        = 1'b1;
    logic [4:0]  address_in    = 5'h00;
    logic        read_in       = 1'b0;
    logic        write_in      = 1'b0;
    logic [31:0] writedata_in  = 32'h0000_0000;
    logic [3:0]  byteenable_in = 4'hf;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    logic [3:0]  osc           = 4'h0;    // the four tick source pins
    logic        timer_pulse_out;
    logic        irq_out;
    logic [31:0] exp_q[$];                // expected read data, oldest first
    logic [31:0] rnd           = 32'hdcb8;
    int          num_errors    = 0;
    int          checked       = 0;
    int          cyc           = 0;
    int          pulse_cnt     = 0;
    int          last_pulse    = 0;
    int          gap           = 0;

    cpu_periodic_down_timer i_cpu_periodic_down_timer (
        .sys_clk_in             (sys_clk_in),
        .rst_in                 (rst_in),
        .address_in             (address_in),
        .read_in                (read_in),
        .write_in               (write_in),
        .writedata_in           (writedata_in),
        .byteenable_in          (byteenable_in),
        .readdata_out           (readdata_out),
        .waitrequest_out        (waitrequest_out),
        .internal_osc_one_in    (osc[0]),
        .internal_osc_two_in    (osc[1]),
        .crystal_clock_in       (osc[2]),
        .auxiliary_pll_clock_in (osc[3]),
        .timer_pulse_out        (timer_pulse_out),
        .irq_out                (irq_out)
    );

    // ------------------------------------------------------------
    // clock, timeout and output watchers
    // ------------------------------------------------------------
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // read answers are taken off the queue at the edge they stand at
    always @(posedge sys_clk_in) begin
        cyc++;
        if (read_in && waitrequest_out === 1'b0) begin
            chk(readdata_out, exp_q.pop_front());
        end
        if (timer_pulse_out === 1'b1) begin
            pulse_cnt++;
            gap        = cyc - last_pulse;
            last_pulse = cyc;
        end
        // timeout is the last step so nothing runs after the verdict
        if (cyc > 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request is held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_in);
        read_in      <= !wr;
        write_in     <= wr;
        address_in   <= a;
        writedata_in <= d;
        do @(posedge sys_clk_in); while (waitrequest_out !== 1'b0);
        read_in  <= 1'b0;
        write_in <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] s,
                                        input logic rl, input logic run);
        return {25'h0, s, 2'b00, rl, run};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int          nv[3] = '{3, 0, 3};
        int          pv[3] = '{0, 0, 2};
        int          base;
        int          e;
        int          etot = 0;
        logic [3:0]  nx;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // reset values and the unmapped place
        rd(OFS_CTRL, 32'h0);
        rd(OFS_PERIOD, RST_PERIOD);
        rd(OFS_PRESCALE, {16'h0, RST_PRESCALE});
        rd(OFS_COUNT, RST_COUNT);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(5'h18, 32'h0);
        // random period, reload with counter stopped, count is read only
        rnd = xs(rnd);
        wr(OFS_PERIOD, rnd);
        wr(OFS_CTRL, ctl(SRC_SYSTEM, 1'b1, 1'b0));
        wr(OFS_COUNT, ~rnd);
        rd(OFS_COUNT, rnd);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        // only the two low byte lanes of the period may change
        byteenable_in <= 4'h3;
        wr(OFS_PERIOD, ~rnd);
        byteenable_in <= 4'hf;
        rd(OFS_PERIOD, {rnd[31:16], ~rnd[15:0]});
        // pulse spacing is (period+1)*(prescale+1) cycles
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_PERIOD, 32'(nv[i]));
            wr(OFS_PRESCALE, 32'(pv[i]));
            wr(OFS_CTRL, ctl(SRC_SYSTEM, 1'b1, 1'b0));
            base = pulse_cnt;
            wr(OFS_CTRL, ctl(SRC_SYSTEM, 1'b0, 1'b1));
            while (pulse_cnt < base + 3) @(posedge sys_clk_in);
            e = (nv[i] + 1) * (pv[i] + 1);
            chk(32'(gap), 32'(e));
            if (i == 1) begin
                // a clear that meets a wrap must lose to the set
                wr(OFS_STATUS, 32'h1);
                rd(OFS_STATUS, 32'h1);
            end
        end
        // sticky flag, mask and write-one clear
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, irq_out}, 32'h0);
        wr(OFS_STATUS, 32'h0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'h1);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, irq_out}, 32'h1);
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk_in);
        chk({31'h0, irq_out}, 32'h0);
        rd(OFS_STATUS, 32'h0);
        // each pin source: period 0 gives one pulse per rising edge
        wr(OFS_PERIOD, 32'h0);
        wr(OFS_PRESCALE, 32'h0);
        for (int s = 1; s <= 5; s++) begin
            wr(OFS_CTRL, ctl(3'(s), 1'b1, 1'b0));
            base = pulse_cnt;
            e    = 0;
            wr(OFS_CTRL, ctl(3'(s), 1'b0, 1'b1));
            for (int k = 0; k < 12; k++) begin
                rnd = xs(rnd);
                nx  = rnd[3:0];
                if (s < 5 && nx[s-1] && !osc[s-1]) e++;
                @(posedge sys_clk_in);
                osc <= nx;
                repeat (7) @(posedge sys_clk_in);
            end
            wr(OFS_CTRL, 32'h0);
            chk(32'(pulse_cnt - base), 32'(e));
            etot += e;
        end
        // the flag was cleared above, so only pin pulses can set it
        rd(OFS_STATUS, {31'h0, (etot != 0)});
        report_and_stop();
    end
endmodule
